// ==== logic/ssww_top.sv ====
// supply supervisor, reset sequencer and window watchdog with AHB-Lite registers
`timescale 1ns/100ps
module ssww_top import ssww_pkg::*; #(
	parameter int OSC_DIV = SSWW_OSC_DIV_DEF,
	parameter int CLOSE_TICKS = SSWW_CLOSE_TICKS_DEF,
	parameter int OPEN_TICKS = SSWW_OPEN_TICKS_DEF,
	parameter int LEAD_TICKS = SSWW_LEAD_TICKS_DEF,
	parameter int RES_TICKS = SSWW_RES_TICKS_DEF,
	parameter int SHORT_TICKS = SSWW_SHORT_TICKS_DEF,
	parameter int DEB_CYCLES = SSWW_DEB_CYCLES_DEF
) (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	// supply and temperature comparators
	input wire logic INTERNAL_SUPPLY_GOOD_I,
	input wire logic VCC_ABOVE_LO_I,
	input wire logic VCC_ABOVE_HI_I,
	input wire logic VBAT_OV_I,
	input wire logic VBAT_UV_I,
	input wire logic TEMP_WARN_I,
	input wire logic TEMP_SHUT_I,
	input wire logic TEMP_HOT_I,
	input wire logic SUPPLY_LEVEL_SELECT_I,
	// microcontroller side
	input wire logic WATCHDOG_TRIGGER_INPUT_I,
	input wire logic TX_I,
	output logic RESET_N_O,
	output logic RX_O,
	output logic SUPPLY_FAULT_FLAG_O,
	output logic THERMAL_FLAG_O,
	output logic LEVEL_5V_O,
	// power stage
	output logic VCC_EN_O,
	output logic [3:0] BRIDGE_EN_O,
	output logic BATTERY_SENSE_SWITCH_O,
	// high-voltage bus line
	input wire logic HV_BUS_LINE_I,
	input wire logic HV_BUS_OVERHEAT_I,
	output logic HV_BUS_LINE_O,
	output logic HV_BUS_LINE_OE_O,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O
);

	localparam logic [SSWW_CNT_W-1:0] CLOSE_LAST = SSWW_CNT_W'(CLOSE_TICKS - 1);
	localparam logic [SSWW_CNT_W-1:0] OPEN_LAST = SSWW_CNT_W'(OPEN_TICKS - 1);
	localparam logic [SSWW_CNT_W-1:0] LEAD_LAST = SSWW_CNT_W'(LEAD_TICKS - 1);
	localparam logic [SSWW_CNT_W-1:0] RES_LAST = SSWW_CNT_W'(RES_TICKS - 1);
	localparam logic [SSWW_CNT_W-1:0] SHORT_LAST = SSWW_CNT_W'(SHORT_TICKS - 1);
	localparam logic [SSWW_DIV_W-1:0] DIV_LAST = SSWW_DIV_W'(OSC_DIV - 1);
	localparam logic [SSWW_DEB_W-1:0] DEB_LAST = SSWW_DEB_W'(DEB_CYCLES - 1);

	initial begin
		if (OSC_DIV < 1 || OSC_DIV > 2 ** SSWW_DIV_W)
			$error("OSC_DIV out of range");
		if (CLOSE_TICKS < 1 || OPEN_TICKS < 1 || LEAD_TICKS < 1 || RES_TICKS < 1 || SHORT_TICKS < 1)
			$error("watchdog tick counts must be at least one");
		if (CLOSE_TICKS > 2 ** SSWW_CNT_W || OPEN_TICKS > 2 ** SSWW_CNT_W || LEAD_TICKS > 2 ** SSWW_CNT_W
			|| RES_TICKS > 2 ** SSWW_CNT_W || SHORT_TICKS > 2 ** SSWW_CNT_W)
			$error("watchdog tick counts exceed counter width");
		if (DEB_CYCLES < 1 || DEB_CYCLES > 2 ** SSWW_DEB_W)
			$error("DEB_CYCLES out of range");
	end

	ssww_state_t s;
	ssww_state_t next_s;
	logic tick;
	logic trig_rise;
	logic rst_act;
	logic bridge_on;

	function automatic ssww_state_t ssww_idle();
		ssww_idle = '0;
		ssww_idle.wd = WD_HOLD;
		ssww_idle.ctrl = SSWW_CTRL_RESET;
		ssww_idle.hready = 1'b1;
		// reset is active in the idle state, so the bus line is pulled low
		ssww_idle.sio_oe = 1'b1; // RL19
	endfunction

	// enter the reset hold, full or shortened
	function automatic ssww_state_t ssww_go_hold(input ssww_state_t st, input logic short_len, input logic by_wd);
		ssww_go_hold = st;
		ssww_go_hold.wd = WD_HOLD;
		ssww_go_hold.cnt = '0;
		ssww_go_hold.short_hold = short_len;
		ssww_go_hold.wd_rst = by_wd;
		ssww_go_hold.trig_ok = 1'b0;
	endfunction

	function automatic ssww_state_t ssww_accept(input ssww_state_t st);
		ssww_accept = st;
		ssww_accept.wd = WD_CLOSED;
		ssww_accept.cnt = '0;
		ssww_accept.trig_ok = 1'b1;
		ssww_accept.ot_latch = 1'b0;
	endfunction

	function automatic logic [31:0] ssww_read(input logic [31:0] addr, input ssww_state_t st);
		ssww_read = '0;
		if (addr == SSWW_ADDR_CTRL) begin
			ssww_read[1:0] = st.ctrl;
		end else if (addr == SSWW_ADDR_STATUS) begin
			ssww_read[SSWW_ST_RESET_BIT] = st.reset_n;
			ssww_read[SSWW_ST_WD_LSB +: 2] = st.wd;
			ssww_read[SSWW_ST_TRIG_BIT] = st.trig_ok;
			ssww_read[SSWW_ST_FAULT_BIT] = st.fault;
			ssww_read[SSWW_ST_THERM_BIT] = st.thermal;
			ssww_read[SSWW_ST_SHUT_BIT] = st.tshut;
			ssww_read[SSWW_ST_VCC_BIT] = st.vcc_ok;
			ssww_read[SSWW_ST_LEVEL_BIT] = st.level_5v;
			ssww_read[SSWW_ST_BATT_BIT] = st.batt_sw;
		end
	endfunction

	always_comb begin
		next_s = s;
		// oscillator tick derived from the system clock
		tick = (s.div == DIV_LAST); // RL10
		next_s.div = tick ? '0 : s.div + 1'b1;
		next_s.trig_s1 = WATCHDOG_TRIGGER_INPUT_I; // RL22
		next_s.trig_s2 = s.trig_s1;
		next_s.trig_s3 = s.trig_s2;
		trig_rise = s.trig_s2 & ~s.trig_s3; // RL11
		next_s.vcc_ok = s.vcc_ok ? VCC_ABOVE_LO_I : VCC_ABOVE_HI_I; // RL16
		if (TEMP_SHUT_I) begin
			next_s.tshut = 1'b1; // RL5
		end else if (!TEMP_HOT_I) begin
			next_s.tshut = 1'b0; // RL6
		end
		if (next_s.tshut || !next_s.vcc_ok) begin
			next_s = ssww_go_hold(next_s, 1'b0, 1'b0); // RL9
		end else begin
			unique case (s.wd)
				WD_HOLD: begin
					if (tick) begin
						if (s.cnt >= (s.short_hold ? SHORT_LAST : RES_LAST)) begin
							next_s.wd = WD_LEAD; // RL12
							next_s.cnt = '0;
						end else begin
							next_s.cnt = s.cnt + 1'b1;
						end
					end
				end
				WD_LEAD: begin
					if (trig_rise) begin
						next_s = ssww_accept(next_s);
					end else if (tick) begin
						if (s.cnt >= LEAD_LAST)
							next_s = ssww_go_hold(next_s, 1'b0, 1'b1); // RL13
						else
							next_s.cnt = s.cnt + 1'b1;
					end
				end
				WD_CLOSED: begin
					if (trig_rise) begin
						next_s = ssww_go_hold(next_s, 1'b1, 1'b1); // RL23
					end else if (tick) begin
						if (s.cnt >= CLOSE_LAST) begin
							next_s.wd = WD_OPEN; // RL14
							next_s.cnt = '0;
						end else begin
							next_s.cnt = s.cnt + 1'b1;
						end
					end
				end
				WD_OPEN: begin
					if (trig_rise) begin
						next_s = ssww_accept(next_s); // RL14
					end else if (tick) begin
						if (s.cnt >= OPEN_LAST)
							next_s = ssww_go_hold(next_s, 1'b1, 1'b1); // RL15
						else
							next_s.cnt = s.cnt + 1'b1;
					end
				end
			endcase
		end
		// shutdown set wins over the clear by a trigger
		if (TEMP_SHUT_I)
			next_s.ot_latch = 1'b1; // RL7
		rst_act = (next_s.wd == WD_HOLD);
		next_s.reset_n = ~rst_act;
		next_s.vcc_en = ~next_s.tshut; // RL12
		bridge_on = next_s.trig_ok & ~VBAT_OV_I & ~VBAT_UV_I & ~next_s.tshut & ~rst_act
			& s.ctrl[SSWW_CTRL_BRIDGE_BIT]; // RL21
		next_s.bridge = {4{bridge_on}}; // RL3
		next_s.fault = VBAT_OV_I | VBAT_UV_I; // RL3
		next_s.thermal = TEMP_WARN_I | next_s.ot_latch; // RL4
		next_s.batt_sw = next_s.vcc_ok | (rst_act & next_s.wd_rst); // RL1
		next_s.sio_out = 1'b0;
		next_s.sio_oe = rst_act // RL19
			| (~TX_I & ~HV_BUS_OVERHEAT_I & ~next_s.tshut & s.ctrl[SSWW_CTRL_TX_BIT]); // RL17 RL18
		// receive debounce
		if (HV_BUS_LINE_I == s.rx) begin
			next_s.deb_cnt = '0;
		end else if (s.deb_cnt >= DEB_LAST) begin
			next_s.rx = HV_BUS_LINE_I; // RL20
			next_s.deb_cnt = '0;
		end else begin
			next_s.deb_cnt = s.deb_cnt + 1'b1;
		end
		if (!s.strap_done) begin
			next_s.level_5v = SUPPLY_LEVEL_SELECT_I; // RL8
			next_s.strap_done = 1'b1;
		end
		// bus data phase, then address phase
		if (s.wr_pend && s.addr == SSWW_ADDR_CTRL)
			next_s.ctrl = HWDATA_I[1:0];
		next_s.hready = 1'b1;
		next_s.hresp = 1'b0;
		if (HREADY_I) begin
			next_s.wr_pend = 1'b0;
			if (HSEL_I && HTRANS_I[1]) begin
				next_s.addr = HADDR_I;
				next_s.wr_pend = HWRITE_I;
				if (!HWRITE_I)
					next_s.hrdata = ssww_read(HADDR_I, s);
			end
		end
		if (!INTERNAL_SUPPLY_GOOD_I)
			next_s = ssww_idle(); // RL2
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			s <= ssww_idle();
		else
			s <= next_s;
	end

	assign RESET_N_O = s.reset_n;
	assign RX_O = s.rx;
	assign SUPPLY_FAULT_FLAG_O = s.fault;
	assign THERMAL_FLAG_O = s.thermal;
	assign LEVEL_5V_O = s.level_5v;
	assign VCC_EN_O = s.vcc_en;
	assign BRIDGE_EN_O = s.bridge;
	assign BATTERY_SENSE_SWITCH_O = s.batt_sw;
	assign HV_BUS_LINE_O = s.sio_out;
	assign HV_BUS_LINE_OE_O = s.sio_oe;
	assign HRDATA_O = s.hrdata;
	assign HREADYOUT_O = s.hready;
	assign HRESP_O = s.hresp;

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);

	a_bus_low_reset: assert property (!RESET_N_O |-> HV_BUS_LINE_OE_O && !HV_BUS_LINE_O) // RL19
		else $error("bus line not pulled low during reset");
	a_vbat_bridge_off: assert property ((VBAT_OV_I || VBAT_UV_I) |=> BRIDGE_EN_O == 4'h0 && SUPPLY_FAULT_FLAG_O) // RL3
		else $error("bridge on or no fault flag on battery alarm");
	a_shut_all_off: assert property (TEMP_SHUT_I |=> !RESET_N_O && !VCC_EN_O && BRIDGE_EN_O == 4'h0) // RL5
		else $error("shutdown did not disable outputs");
	a_warn_flag: assert property (TEMP_WARN_I |=> THERMAL_FLAG_O) // RL4
		else $error("thermal warning not flagged");
	a_shut_latched: assert property (s.tshut && TEMP_HOT_I && !TEMP_SHUT_I && INTERNAL_SUPPLY_GOOD_I |=> s.tshut) // RL6
		else $error("shutdown left before cooling");
	a_vcc_low_reset: assert property (!VCC_ABOVE_LO_I |=> !RESET_N_O) // RL9
		else $error("reset not held with low supply");
	a_internal_supply_hold: assert property (!INTERNAL_SUPPLY_GOOD_I |=> !RESET_N_O && !VCC_EN_O) // RL2
		else $error("logic not held in reset on internal supply loss");
	a_closed_trig: assert property (s.wd == WD_CLOSED && trig_rise |=> !RESET_N_O && s.short_hold) // RL23
		else $error("closed window trigger not punished");
	a_bridge_trig: assert property (BRIDGE_EN_O != 4'h0 |-> s.trig_ok && RESET_N_O) // RL21
		else $error("bridge enabled without accepted trigger");
	a_batt_sw_wd: assert property (s.wd == WD_HOLD && s.wd_rst |-> BATTERY_SENSE_SWITCH_O) // RL1
		else $error("battery switch open during watchdog reset");
	a_strap_stable: assert property (s.strap_done && $past(s.strap_done) && INTERNAL_SUPPLY_GOOD_I |-> $stable(LEVEL_5V_O)) // RL8
		else $error("supply level changed after capture");
	a_ot_latch: assert property (s.ot_latch && !trig_rise && INTERNAL_SUPPLY_GOOD_I |=> THERMAL_FLAG_O) // RL7
		else $error("shutdown latch lost before trigger");

	c_trig_accepted: cover property (s.wd == WD_OPEN && trig_rise);
	c_short_reset: cover property (s.wd == WD_HOLD && s.short_hold);
	c_lead_timeout: cover property (s.wd == WD_LEAD ##1 s.wd == WD_HOLD && !s.short_hold && s.wd_rst);
	c_thermal_shut: cover property ($rose(s.tshut));

endmodule // ssww_top

// ==== logic/ssww_pkg.sv ====
// constants, types and timing of the supply supervisor and window watchdog
// Behaviour
// [RL1] battery-sense switch on while supply good, and during a watchdog reset
// [RL2] all logic held in reset while the internal supply is not good
// [RL3] battery over/undervoltage turns bridge drivers off and sets the supply fault flag
// [RL4] thermal flag high at the warning temperature, block stays functional
// [RL5] shutdown temperature turns off regulator, bridge, bus driver and asserts reset; the code keeps the bus line driven low during that reset
// [RL6] after shutdown, operation resumes only below the recovery temperature
// [RL7] a shutdown is latched in the thermal flag until the next accepted trigger
// [RL8] supply level select is a strap, captured once after reset and held
// [RL9] microcontroller reset held while the external supply is too low
// [RL10] all watchdog timing counts ticks of the internal trimmed oscillator
// [RL11] microcontroller gives one rising trigger edge per watchdog period
// [RL12] after power-on enable regulator, hold reset for hold time, then release
// [RL13] no trigger within lead time after release gives a full hold reset again
// [RL14] closed window then open window; accepted trigger restarts from closed window
// [RL15] missed or misplaced trigger gives a short reset, then the start sequence
// [RL16] supply reset uses separate assert and release levels for hysteresis
// [RL17] transmit input level is passed to the bus line driver
// [RL18] bus transmission stops while the bus driver reports overheating
// [RL19] bus line driven low while reset is active, regardless of temperature
// [RL20] bus receive comparator is debounced before reaching the receive output
// [RL21] bridge enabled only after one accepted trigger plus supply and temperature ok
// [RL22] trigger synchronised, all windows counted in oscillator ticks
// [RL23] trigger edge inside the closed window starts the short reset
package ssww_pkg;

	localparam int SSWW_CLK_PERIOD_PS = 4000;
	localparam int SSWW_OSC_PERIOD_NS = 12320;
	localparam int SSWW_OSC_DIV_DEF = (SSWW_OSC_PERIOD_NS * 1000 + SSWW_CLK_PERIOD_PS - 1) / SSWW_CLK_PERIOD_PS;

	// watchdog times in microseconds
	localparam int SSWW_T_CLOSE_US = 12100;
	localparam int SSWW_T_OPEN_US = 9610;
	localparam int SSWW_T_RES_US = 70000;
	localparam int SSWW_T_LEAD_US = 70000;
	localparam int SSWW_T_SHORT_US = 2000;

	// windows round down, hold times round up
	localparam int SSWW_CLOSE_TICKS_DEF = (SSWW_T_CLOSE_US * 1000) / SSWW_OSC_PERIOD_NS;
	localparam int SSWW_OPEN_TICKS_DEF = (SSWW_T_OPEN_US * 1000) / SSWW_OSC_PERIOD_NS;
	localparam int SSWW_LEAD_TICKS_DEF = (SSWW_T_LEAD_US * 1000) / SSWW_OSC_PERIOD_NS;
	localparam int SSWW_RES_TICKS_DEF = (SSWW_T_RES_US * 1000 + SSWW_OSC_PERIOD_NS - 1) / SSWW_OSC_PERIOD_NS;
	localparam int SSWW_SHORT_TICKS_DEF = (SSWW_T_SHORT_US * 1000 + SSWW_OSC_PERIOD_NS - 1) / SSWW_OSC_PERIOD_NS;
	localparam int SSWW_DEB_CYCLES_DEF = 16;

	localparam int SSWW_CNT_W = 16;
	localparam int SSWW_DIV_W = 16;
	localparam int SSWW_DEB_W = 8;

	// register map
	localparam logic [31:0] SSWW_ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] SSWW_ADDR_STATUS = 32'h0000_0004;
	localparam int SSWW_CTRL_BRIDGE_BIT = 0;
	localparam int SSWW_CTRL_TX_BIT = 1;
	localparam logic [1:0] SSWW_CTRL_RESET = 2'h3;
	localparam int SSWW_ST_RESET_BIT = 0;
	localparam int SSWW_ST_WD_LSB = 1;
	localparam int SSWW_ST_TRIG_BIT = 3;
	localparam int SSWW_ST_FAULT_BIT = 4;
	localparam int SSWW_ST_THERM_BIT = 5;
	localparam int SSWW_ST_SHUT_BIT = 6;
	localparam int SSWW_ST_VCC_BIT = 7;
	localparam int SSWW_ST_LEVEL_BIT = 8;
	localparam int SSWW_ST_BATT_BIT = 9;
	localparam logic [1:0] SSWW_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		WD_HOLD,
		WD_LEAD,
		WD_CLOSED,
		WD_OPEN
	} ssww_wd_t;

	typedef struct packed {
		ssww_wd_t wd;
		logic [SSWW_CNT_W-1:0] cnt;
		logic [SSWW_DIV_W-1:0] div;
		logic short_hold;
		logic wd_rst;
		logic trig_ok;
		logic trig_s1;
		logic trig_s2;
		logic trig_s3;
		logic vcc_ok;
		logic tshut;
		logic ot_latch;
		logic strap_done;
		logic level_5v;
		logic [SSWW_DEB_W-1:0] deb_cnt;
		logic rx;
		logic reset_n;
		logic vcc_en;
		logic [3:0] bridge;
		logic fault;
		logic thermal;
		logic batt_sw;
		logic sio_out;
		logic sio_oe;
		logic [1:0] ctrl;
		logic wr_pend;
		logic [31:0] addr;
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
	} ssww_state_t;

endpackage

// ==== tb/ssww_mcu_model.sv ====
// microcontroller model: watchdog trigger source
`timescale 1ns/100ps
module ssww_mcu_model (
	// clock and mcu reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// trigger spacing in clocks, zero stops triggering
	input wire logic [7:0] gap_i,
	// trigger output
	output logic trig_o
);
	logic [7:0] cnt;
	// first edge half a gap after reset release, then one per gap
	always @(posedge clk_i) begin
		if (rst_n_i !== 1'b1) begin
			cnt <= gap_i >> 1;
			trig_o <= 1'b0;
		end else if (gap_i != 8'h00) begin
			cnt <= (cnt == gap_i - 8'h01) ? 8'h00 : cnt + 8'h01;
			if (cnt == gap_i - 8'h01) begin
				trig_o <= 1'b1;
			end else if (cnt == 8'h02) begin
				trig_o <= 1'b0;
			end
		end
	end
endmodule // ssww_mcu_model

// ==== tb/ssww_top_tb.sv ====
// self-checking bench of the supervisor and window watchdog
`timescale 1ns/100ps
module ssww_top_tb import ssww_pkg::*;;
	logic MCLK_I = 1'b0, RESET_N_I = 1'b0, INTERNAL_SUPPLY_GOOD_I = 1'b1, VCC_ABOVE_LO_I = 1'b1, VCC_ABOVE_HI_I = 1'b1;
	logic VBAT_OV_I = 1'b0, VBAT_UV_I = 1'b0, TEMP_WARN_I = 1'b0, TEMP_SHUT_I = 1'b0, TEMP_HOT_I = 1'b0;
	logic SUPPLY_LEVEL_SELECT_I = 1'b1, TX_I = 1'b1, HV_BUS_OVERHEAT_I = 1'b0, HSEL_I = 1'b1, HWRITE_I = 1'b0;
	logic [1:0] HTRANS_I = 2'h0;
	logic [2:0] HSIZE_I = 3'h2;
	logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, rd;
	logic WATCHDOG_TRIGGER_INPUT_I, RESET_N_O, RX_O, SUPPLY_FAULT_FLAG_O, THERMAL_FLAG_O, LEVEL_5V_O, VCC_EN_O;
	logic BATTERY_SENSE_SWITCH_O, HV_BUS_LINE_O, HV_BUS_LINE_OE_O, HREADYOUT_O, HRESP_O, remote_low = 1'b0;
	logic [3:0] BRIDGE_EN_O;
	logic [7:0] gap = 8'h00;
	int fail_count = 0, num_checks = 0, n;
	// pulled-up bus line, low while either end pulls
	wire logic HV_BUS_LINE_I = !(HV_BUS_LINE_OE_O | remote_low);
	wire logic HREADY_I = HREADYOUT_O;

	initial begin
		forever #2 MCLK_I = ~MCLK_I;
	end

	ssww_top #(.OSC_DIV(4), .CLOSE_TICKS(6), .OPEN_TICKS(6), .LEAD_TICKS(8), .RES_TICKS(8), .SHORT_TICKS(3),
		.DEB_CYCLES(2)) u_ssww_top (.MCLK_I, .RESET_N_I, .INTERNAL_SUPPLY_GOOD_I, .VCC_ABOVE_LO_I, .VCC_ABOVE_HI_I,
		.VBAT_OV_I, .VBAT_UV_I, .TEMP_WARN_I, .TEMP_SHUT_I, .TEMP_HOT_I, .SUPPLY_LEVEL_SELECT_I,
		.WATCHDOG_TRIGGER_INPUT_I, .TX_I, .RESET_N_O, .RX_O, .SUPPLY_FAULT_FLAG_O, .THERMAL_FLAG_O, .LEVEL_5V_O,
		.VCC_EN_O, .BRIDGE_EN_O, .BATTERY_SENSE_SWITCH_O, .HV_BUS_LINE_I, .HV_BUS_OVERHEAT_I, .HV_BUS_LINE_O,
		.HV_BUS_LINE_OE_O, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I, .HREADY_I, .HRDATA_O,
		.HREADYOUT_O, .HRESP_O);
	ssww_mcu_model u_ssww_mcu_model (.clk_i(MCLK_I), .rst_n_i(RESET_N_O), .gap_i(gap),
		.trig_o(WATCHDOG_TRIGGER_INPUT_I));

	task automatic close_out();
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge MCLK_I);
		// look once the registered outputs have settled
		#1;
	endtask
	// cycles until the mcu reset shows level v
	task automatic wait_rst(input logic v, output int k);
		k = 0;
		while (RESET_N_O !== v) begin
			@(posedge MCLK_I);
			k++;
			if (k > 200) begin
				chk("reset_wait", v, RESET_N_O);
				close_out();
			end
		end
	endtask
	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge MCLK_I);
		while (HREADYOUT_O !== 1'b1) begin
			@(posedge MCLK_I);
			i++;
			if (i > 20) begin
				chk("hready", 1, HREADYOUT_O);
				close_out();
			end
		end
	endtask
	// one single word transfer, read data left in rd
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		HTRANS_I <= SSWW_HTRANS_NONSEQ;
		HADDR_I <= a;
		HWRITE_I <= wr;
		wait_rdy();
		HTRANS_I <= 2'h0;
		HWDATA_I <= wd;
		wait_rdy();
		rd = HRDATA_O;
	endtask

	initial begin
		cyc(3);
		RESET_N_I <= 1'b1;
		cyc(2);
		chk("vcc_en", 1, VCC_EN_O);
		chk("bridge_idle", 0, BRIDGE_EN_O);
		chk("oe_rst", 1, HV_BUS_LINE_OE_O);
		chk("level", 1, LEVEL_5V_O);
		wait_rst(1, n);
		chk("hold_len", 1, n >= 24 && n <= 40);
		wait_rst(0, n);
		chk("lead_len", 1, n >= 26 && n <= 42);
		chk("batt_wd", 1, BATTERY_SENSE_SWITCH_O);
		gap <= 8'd36;
		wait_rst(1, n);
		chk("rehold_len", 1, n >= 26 && n <= 42);
		ahb(0, SSWW_ADDR_CTRL, 0);
		chk("ctrl_rst", SSWW_CTRL_RESET, rd);
		ahb(0, 32'h0000_0010, 0);
		chk("unmapped", 0, rd);
		n = 0;
		for (int k = 0; k < 300; k++) begin
			@(posedge MCLK_I);
			n += int'(RESET_N_O !== 1'b1);
		end
		chk("wd_steady", 0, n);
		chk("bridge_on", 4'hF, BRIDGE_EN_O);
		for (int k = 0; k < 2; k++) begin
			VBAT_OV_I <= (k == 0);
			VBAT_UV_I <= (k == 1);
			cyc(3);
			chk("alarm_bridge", 0, BRIDGE_EN_O);
			chk("alarm_flag", 1, SUPPLY_FAULT_FLAG_O);
			chk("alarm_rst", 1, RESET_N_O);
		end
		VBAT_UV_I <= 1'b0;
		ahb(1, SSWW_ADDR_CTRL, 2);
		cyc(2);
		chk("ctrl_bridge", 0, BRIDGE_EN_O);
		ahb(0, SSWW_ADDR_CTRL, 0);
		chk("ctrl_wr", 2, rd);
		HSEL_I <= 1'b0;
		ahb(1, SSWW_ADDR_CTRL, 0);
		HSEL_I <= 1'b1;
		ahb(0, SSWW_ADDR_CTRL, 0);
		chk("desel_wr", 2, rd);
		ahb(1, SSWW_ADDR_CTRL, 3);
		TX_I <= 1'b0;
		cyc(3);
		chk("tx_low", 1, HV_BUS_LINE_OE_O);
		chk("tx_data", 0, HV_BUS_LINE_O);
		HV_BUS_OVERHEAT_I <= 1'b1;
		cyc(3);
		chk("overheat", 0, HV_BUS_LINE_OE_O);
		HV_BUS_OVERHEAT_I <= 1'b0;
		TX_I <= 1'b1;
		cyc(3);
		chk("tx_high", 0, HV_BUS_LINE_OE_O);
		cyc(6);
		chk("rx_idle", 1, RX_O);
		remote_low <= 1'b1;
		cyc(1);
		chk("rx_deb", 1, RX_O);
		cyc(8);
		chk("rx_low", 0, RX_O);
		remote_low <= 1'b0;
		SUPPLY_LEVEL_SELECT_I <= 1'b0;
		cyc(4);
		chk("strap", 1, LEVEL_5V_O);
		SUPPLY_LEVEL_SELECT_I <= 1'b1;
		TEMP_WARN_I <= 1'b1;
		cyc(3);
		chk("warn_flag", 1, THERMAL_FLAG_O);
		chk("warn_run", 4'hF, BRIDGE_EN_O);
		TEMP_WARN_I <= 1'b0;
		TEMP_SHUT_I <= 1'b1;
		TEMP_HOT_I <= 1'b1;
		HV_BUS_OVERHEAT_I <= 1'b1;
		cyc(3);
		chk("shut_rst", 0, RESET_N_O);
		chk("shut_vcc", 0, VCC_EN_O);
		chk("shut_bridge", 0, BRIDGE_EN_O);
		chk("shut_bus", 1, HV_BUS_LINE_OE_O);
		TEMP_SHUT_I <= 1'b0;
		HV_BUS_OVERHEAT_I <= 1'b0;
		cyc(10);
		chk("hyst", 0, VCC_EN_O);
		TEMP_HOT_I <= 1'b0;
		cyc(3);
		chk("recover", 1, VCC_EN_O);
		chk("latch", 1, THERMAL_FLAG_O);
		wait_rst(1, n);
		cyc(30);
		chk("latch_clr", 0, THERMAL_FLAG_O);
		VCC_ABOVE_LO_I <= 1'b0;
		VCC_ABOVE_HI_I <= 1'b0;
		cyc(3);
		chk("vcc_rst", 0, RESET_N_O);
		chk("vcc_sw", 0, BATTERY_SENSE_SWITCH_O);
		VCC_ABOVE_LO_I <= 1'b1;
		gap <= 8'd8;
		cyc(50);
		chk("vcc_hyst", 0, RESET_N_O);
		VCC_ABOVE_HI_I <= 1'b1;
		wait_rst(1, n);
		chk("vcc_hold", 1, n >= 26 && n <= 42);
		wait_rst(0, n);
		chk("batt_short", 1, BATTERY_SENSE_SWITCH_O);
		wait_rst(1, n);
		chk("short_len", 1, n >= 7 && n <= 18);
		ahb(1, SSWW_ADDR_CTRL, 0);
		INTERNAL_SUPPLY_GOOD_I <= 1'b0;
		cyc(3);
		chk("internal_supply_vcc", 0, VCC_EN_O);
		chk("internal_supply_rst", 0, RESET_N_O);
		INTERNAL_SUPPLY_GOOD_I <= 1'b1;
		cyc(2);
		ahb(0, SSWW_ADDR_CTRL, 0);
		chk("internal_supply_ctrl", SSWW_CTRL_RESET, rd);
		close_out();
	end
endmodule // ssww_top_tb
